// ### hw/acq_pkg.sv
// Behaviour
// - five acquisition modes; exactly one is active at any time.
// - status LED blink pattern shows the active acquisition mode.
// - free-run makes its own trigger and acquires frames continuously.
// - free-run trigger period follows from the longer of exposure time and readout time.
// - free-run always overlaps next exposure with previous readout.
// - external trigger comes from the grabber line or the trigger pin.
// - master modes take exposure length from the held programmed value.
// - in master modes a valid trigger starts the programmed exposure at once.
// - non-overlapped modes start readout only after exposure has ended.
// - non-overlapped modes ignore triggers during readout.
// - master mode trigger during exposure restarts it; old frame discarded.
// - non-overlapped modes go idle after exposure and readout complete.
// - master overlap accepts triggers during readout, exposing concurrently.
// - overlap modes begin readout exactly when exposure ends.
// - overlap modes ignore triggers during exposure or under 224.7 ms apart.
// - reading out one frame takes 224.7 ms.
// - slave exposure lasts from trigger detection until trigger drops.
// - slave overlap accepts triggers during readout, exposing concurrently.
// - trigger pulses narrower than 100 us are rejected, no image taken.
// - strobe output starts and lasts exactly with the exposure.
package acq_pkg;
	typedef enum logic [2:0] {
		mode_free,
		mode_master,
		mode_master_ovl,
		mode_slave,
		mode_slave_ovl
	} mode_t;

	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned READOUT_US = 224700;
	localparam int unsigned READOUT_CYC = READOUT_US * CLK_MHZ;
	localparam int unsigned MIN_PULSE_US = 100;
	localparam int unsigned MIN_PULSE_CYC = MIN_PULSE_US * CLK_MHZ;
	localparam int unsigned LED_UNIT_MS = 100;
	localparam int unsigned LED_UNIT_CYC = LED_UNIT_MS * 1000 * CLK_MHZ;
	localparam int unsigned LED_STEPS = 16;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [31:0] EXP_RESET = 32'h001e8480;
endpackage

// ### hw/trig_if.sv
`timescale 1ns/1ps
interface trig_if;
	logic start;
	logic level;
	modport src(output start, output level);
	modport dst(input start, input level);
endinterface

// ### hw/trig_qual.sv
`timescale 1ns/1ps
module trig_qual #(
	parameter int unsigned MIN_CYC = acq_pkg::MIN_PULSE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trig_cc,
	input wire logic trig_ext,
	input wire logic src_ext,
	input wire logic pol_high,
	trig_if.src t
);
	import acq_pkg::*;

	if (MIN_CYC < 1) $error("minimum pulse width must be one cycle or more");

	logic raw;
	logic act;
	logic [31:0] cnt;

	assign raw = src_ext ? trig_ext : trig_cc;
	assign act = pol_high ? raw : ~raw;

	// width counter saturates so a long pulse stays qualified
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 32'h0;
		end else if (!act) begin
			cnt <= 32'h0;
		end else if (cnt < 32'(MIN_CYC)) begin
			cnt <= cnt + 32'h1;
		end
	end

	// short pulses never reach the count and never start a frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			t.start <= 1'b0;
			t.level <= 1'b0;
		end else begin
			t.start <= act && cnt == 32'(MIN_CYC - 1);
			t.level <= act && cnt >= 32'(MIN_CYC - 1);
		end
	end

	short_reject_a: assert property (@(posedge clk) disable iff (!rst_n)
		t.start |-> $past(cnt) == 32'(MIN_CYC - 1) && $past(act))
		else $error("trigger started without full minimum width");
endmodule

// ### hw/led_pattern.sv
`timescale 1ns/1ps
module led_pattern #(
	parameter int unsigned UNIT_CYC = acq_pkg::LED_UNIT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire acq_pkg::mode_t mode,
	output logic led
);
	import acq_pkg::*;

	if (UNIT_CYC < 1) $error("led unit must be one cycle or more");

	logic [31:0] unit_cnt;
	logic [3:0] step;
	logic [3:0] blinks;

	// mode n gives n+1 short flashes, then a dark gap
	assign blinks = 4'({1'b0, mode}) + 4'h1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_cnt <= 32'h0;
			step <= 4'h0;
		end else if (unit_cnt == 32'(UNIT_CYC - 1)) begin
			unit_cnt <= 32'h0;
			step <= step + 4'h1;
		end else begin
			unit_cnt <= unit_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			led <= 1'b0;
		end else begin
			led <= !step[0] && (step >> 1) < blinks;
		end
	end

	led_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
		step == 4'hf |=> !led)
		else $error("led lit inside the dark gap");
endmodule

// ### hw/acq_sequencer.sv
`timescale 1ns/1ps
module acq_sequencer #(
	parameter int unsigned READOUT_CYC = acq_pkg::READOUT_CYC,
	parameter int unsigned MIN_PULSE_CYC = acq_pkg::MIN_PULSE_CYC,
	parameter int unsigned LED_UNIT_CYC = acq_pkg::LED_UNIT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] cfg_mode,
	input wire logic [31:0] cfg_exp_cyc,
	input wire logic trig_cc,
	input wire logic trig_ext,
	input wire logic src_ext,
	input wire logic pol_high,
	output logic strobe,
	output logic reading,
	output logic frame_start,
	output logic frame_drop,
	output logic trig_ack,
	output acq_pkg::mode_t active_mode,
	output logic led
);
	import acq_pkg::*;

	if (READOUT_CYC < 2) $error("readout must be two cycles or more");
	if (MIN_PULSE_CYC < 1) $error("minimum pulse must be one cycle or more");

	trig_if t();

	logic exposing;
	logic [31:0] exp_cnt;
	logic [31:0] exp_len;
	logic [31:0] rd_cnt;
	logic [31:0] gap_cnt;
	logic [31:0] period;
	logic gap_full;
	logic fire;
	logic exp_end;
	logic rd_end;
	logic slave_kind;
	logic ovl_kind;
	logic idle;
	logic free_cfg;

	////////////////////////////////////////////////////////////////////
	// helpers

	trig_qual #(.MIN_CYC(MIN_PULSE_CYC)) u_qual (
		.clk(clk),
		.rst_n(rst_n),
		.trig_cc(trig_cc),
		.trig_ext(trig_ext),
		.src_ext(src_ext),
		.pol_high(pol_high),
		.t(t.src)
	);

	led_pattern #(.UNIT_CYC(LED_UNIT_CYC)) u_led (
		.clk(clk),
		.rst_n(rst_n),
		.mode(active_mode),
		.led(led)
	);

	////////////////////////////////////////////////////////////////////
	// configuration

	assign slave_kind = active_mode == mode_slave ||
		active_mode == mode_slave_ovl;
	assign ovl_kind = active_mode == mode_master_ovl ||
		active_mode == mode_slave_ovl;
	assign idle = !exposing && !reading;
	// a pending switch out of free-run must not start a stray frame
	assign free_cfg = cfg_mode == 3'h0 || cfg_mode > 3'h4;

	// free-run never drains its readout, so it may switch between exposures
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_mode <= mode_t'(MODE_RESET);
			exp_len <= EXP_RESET;
		end else if (idle || (active_mode == mode_free && !exposing)) begin
			active_mode <= cfg_mode > 3'h4 ? mode_free : mode_t'(cfg_mode);
			exp_len <= cfg_exp_cyc == 32'h0 ? 32'h1 : cfg_exp_cyc;
		end
	end

	////////////////////////////////////////////////////////////////////
	// trigger acceptance

	assign gap_full = gap_cnt >= 32'(READOUT_CYC);
	assign period = exp_len > 32'(READOUT_CYC) ? exp_len : 32'(READOUT_CYC);

	always_comb begin
		fire = 1'b0;
		case (active_mode)
			mode_free: fire = !exposing && gap_cnt >= period && free_cfg;
			mode_master: fire = t.start && !reading;
			mode_master_ovl: fire = t.start && !exposing && gap_full;
			mode_slave: fire = t.start && idle;
			mode_slave_ovl: fire = t.start && !exposing && gap_full;
			default: fire = 1'b0;
		endcase
	end

	// starts saturated so the first trigger after reset is taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt <= 32'(READOUT_CYC);
		end else if (fire) begin
			gap_cnt <= 32'h1;
		end else if (gap_cnt < period) begin
			gap_cnt <= gap_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_ack <= 1'b0;
		end else begin
			trig_ack <= fire && active_mode != mode_free;
		end
	end

	////////////////////////////////////////////////////////////////////
	// exposure

	// slave length is the trigger width; others count the programmed value
	assign exp_end = exposing && !fire && (slave_kind ? !t.level :
		exp_cnt == exp_len - 32'h1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exposing <= 1'b0;
			exp_cnt <= 32'h0;
		end else if (fire) begin
			exposing <= 1'b1;
			exp_cnt <= 32'h0;
		end else if (exp_end) begin
			exposing <= 1'b0;
		end else if (exposing) begin
			exp_cnt <= exp_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe <= 1'b0;
		end else begin
			strobe <= fire || (exposing && !exp_end);
		end
	end

	// restarted exposure throws its frame away without readout
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_drop <= 1'b0;
		end else begin
			frame_drop <= fire && exposing;
		end
	end

	////////////////////////////////////////////////////////////////////
	// readout

	assign rd_end = reading && rd_cnt == 32'(READOUT_CYC - 1);

	// a new exposure end restarts the readout timer for the fresh frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reading <= 1'b0;
			rd_cnt <= 32'h0;
		end else if (exp_end) begin
			reading <= 1'b1;
			rd_cnt <= 32'h0;
		end else if (rd_end) begin
			reading <= 1'b0;
		end else if (reading) begin
			rd_cnt <= rd_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_start <= 1'b0;
		end else begin
			frame_start <= exp_end;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	one_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
		active_mode inside {mode_free, mode_master, mode_master_ovl,
			mode_slave, mode_slave_ovl})
		else $error("no valid acquisition mode");

	ro_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
		exp_end |=> frame_start && reading && rd_cnt == 32'h0 && !strobe)
		else $error("readout did not follow exposure end");

	ro_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
		(active_mode == mode_master || active_mode == mode_slave) &&
		reading && t.start |=> !trig_ack && !frame_drop)
		else $error("trigger taken during readout");

	exp_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		active_mode == mode_master && exposing && t.start && !reading
		|=> frame_drop && strobe && exp_cnt == 32'h0 && !frame_start)
		else $error("exposure not restarted on new trigger");

	ovl_reject_a: assert property (@(posedge clk) disable iff (!rst_n)
		ovl_kind && t.start && (exposing || !gap_full) |=> !trig_ack)
		else $error("overlap trigger taken too early");

	ovl_take_a: assert property (@(posedge clk) disable iff (!rst_n)
		ovl_kind && t.start && reading && !exposing && gap_full
		|=> trig_ack && strobe && !frame_drop)
		else $error("overlap trigger during readout not taken");

	ro_length_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_end && !exp_end |=> !reading && !frame_start)
		else $error("readout did not end on time");

	exp_length_a: assert property (@(posedge clk) disable iff (!rst_n)
		!slave_kind && exposing && !fire && exp_cnt == exp_len - 32'h1
		|=> !strobe && frame_start)
		else $error("programmed exposure length wrong");

	slave_end_a: assert property (@(posedge clk) disable iff (!rst_n)
		slave_kind && exposing && !t.level && !fire |=> !strobe && frame_start)
		else $error("slave exposure did not end with trigger");

	free_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
		active_mode == mode_free && !exposing && gap_cnt >= period &&
		free_cfg |=> strobe && gap_cnt == 32'h1)
		else $error("free-run did not retrigger");

	cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		exposing |=> $stable(active_mode) && $stable(exp_len))
		else $error("configuration changed mid frame");

	strobe_match_a: assert property (@(posedge clk) disable iff (!rst_n)
		strobe == $past(exposing || fire) || $past(exp_end))
		else $error("strobe not aligned with exposure");

	ack_not_free_a: assert property (@(posedge clk) disable iff (!rst_n)
		active_mode == mode_free |=> !trig_ack)
		else $error("trigger acknowledged in free-run");

	ack_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
		trig_ack |-> strobe)
		else $error("accepted trigger without exposure");

	ack_single_a: assert property (@(posedge clk) disable iff (!rst_n)
		trig_ack |=> !trig_ack)
		else $error("trigger acknowledged twice in a row");

	drop_master_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_drop |-> $past(active_mode) == mode_master)
		else $error("frame dropped outside master mode");

	slave_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
		active_mode == mode_slave && !idle |=> !trig_ack)
		else $error("slave trigger taken while busy");

	plain_serial_a: assert property (@(posedge clk) disable iff (!rst_n)
		(active_mode == mode_master || active_mode == mode_slave) &&
		exposing |-> !reading)
		else $error("exposure overlaps readout in plain mode");

	start_reading_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_start |-> reading)
		else $error("frame start without readout");

	start_single_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_start |=> !frame_start)
		else $error("frame start longer than one cycle");

	strobe_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(strobe) |-> frame_start)
		else $error("strobe fell without readout start");

	strobe_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(strobe) |-> $past(fire) && exp_cnt == 32'h0)
		else $error("strobe rose without accepted trigger");

	strobe_exp_a: assert property (@(posedge clk) disable iff (!rst_n)
		strobe == exposing)
		else $error("strobe differs from exposure");

	read_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		reading |-> rd_cnt < 32'(READOUT_CYC))
		else $error("readout counter overran");

	exp_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		exposing && !slave_kind |-> exp_cnt < exp_len)
		else $error("exposure counter overran");

	ovl_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
		trig_ack && $past(ovl_kind) |-> $past(gap_full) && !$past(exposing))
		else $error("overlap trigger taken inside the gap");

	free_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		active_mode == mode_free && !exposing && gap_cnt < period
		|=> !strobe)
		else $error("free-run fired before its period");
endmodule

// ### verification/trig_source.sv
`timescale 1ns/1ps
module trig_source (
	input wire logic clk,
	output logic trig_cc,
	output logic trig_ext
);
	logic act;
	initial begin
		act = 1'b1;
		trig_cc = 1'b0;
		trig_ext = 1'b0;
	end
	// both lines rest at the inactive level between pulses
	task automatic set_pol(input logic high);
		act = high;
		trig_cc = ~high;
		trig_ext = ~high;
	endtask
	// width counts clock samples; the caller only goes short to test refusal
	task automatic pulse(input logic on_ext, input int width);
		@(posedge clk);
		#1;
		if (on_ext) begin
			trig_ext = act;
		end else begin
			trig_cc = act;
		end
		repeat (width) @(posedge clk);
		#1;
		trig_cc = ~act;
		trig_ext = ~act;
	endtask
endmodule

// ### verification/acq_sequencer_bench.sv
`timescale 1ns/1ps
module acq_sequencer_bench;
	import acq_pkg::*;
	localparam int RD = 40;
	localparam int MP = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] cfg_mode = 3'h0;
	logic [31:0] cfg_exp_cyc = 32'h0000000a;
	logic src_ext = 1'b0;
	logic pol_high = 1'b1;
	logic trig_cc;
	logic trig_ext;
	logic strobe;
	logic reading;
	logic frame_start;
	logic frame_drop;
	logic trig_ack;
	logic led;
	mode_t active_mode;
	int mismatches = 0;
	int samples_checked = 0;
	logic hit;
	int a;
	int b;

	always #2.5 clk = ~clk;

	trig_source src (.clk(clk), .trig_cc(trig_cc), .trig_ext(trig_ext));

	// short counts keep the run small; expectations derive from RD and MP
	acq_sequencer #(.READOUT_CYC(RD), .MIN_PULSE_CYC(MP), .LED_UNIT_CYC(2)) dut (
		.clk(clk), .rst_n(rst_n), .cfg_mode(cfg_mode),
		.cfg_exp_cyc(cfg_exp_cyc), .trig_cc(trig_cc), .trig_ext(trig_ext),
		.src_ext(src_ext), .pol_high(pol_high), .strobe(strobe),
		.reading(reading), .frame_start(frame_start),
		.frame_drop(frame_drop), .trig_ack(trig_ack),
		.active_mode(active_mode), .led(led)
	);

////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("mismatches %0d checks %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: flag %b want %b", $time, got, exp);
		end
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return strobe;
			1: return reading;
			2: return trig_ack;
			3: return frame_drop;
			4: return !strobe;
			default: return !reading;
		endcase
	endfunction

	// every task starts and ends 1 ns after a rising edge
	task automatic watch(input int sel, input int lim, output logic h,
			output int cnt);
		cnt = 0;
		while (pick(sel) !== 1'b1 && cnt < lim) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		h = (pick(sel) === 1'b1);
	endtask

	task automatic wait_sig(input int sel, input int lim, output int cnt);
		logic h;
		watch(sel, lim, h, cnt);
		if (!h) begin
			mismatches++;
			$display("unexpected at %0t: wait ran out", $time);
			finish_test();
		end
	endtask

	task automatic fire(input logic on_ext, input int w, input int sel,
			input int lim, output logic h, output int cnt);
		fork
			src.pulse(on_ext, w);
		join_none
		watch(sel, lim, h, cnt);
	endtask

	task automatic set_cfg(input logic [2:0] m, input logic [31:0] e);
		int c;
		cfg_mode = m;
		cfg_exp_cyc = e;
		wait_sig(4, 200, c);
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic period(output int w, output int p);
		int c;
		wait_sig(4, 200, c);
		wait_sig(0, 200, c);
		wait_sig(4, 200, w);
		wait_sig(0, 200, c);
		p = w + c;
	endtask

////////////////////////////////////////////////////////////////////////////////
	task automatic modes_and_led();
		int m;
		int rises;
		logic prev;
		for (int i = 0; i < 5; i++) begin
			m = (i + 1) % 5;
			set_cfg(m[2:0], 32'h0000000a);
			check_val(32'(active_mode), 32'(m));
			repeat (40) @(posedge clk);
			#1;
			rises = 0;
			prev = led;
			repeat (32) begin
				@(posedge clk);
				#1;
				if (led === 1'b1 && prev !== 1'b1) rises++;
				prev = led;
			end
			check_val(32'(rises), 32'(m + 1));
		end
	endtask

	task automatic free_run();
		set_cfg(3'h0, 32'h0000000a);
		period(a, b);
		check_val(32'(a), 32'h0000000a);
		check_val(32'(b), 32'(RD));
		fire(1'b0, 6, 2, 15, hit, a);
		check_flag(hit, 1'b0);
		cfg_exp_cyc = 32'h0000003c;
		period(a, b);
		period(a, b);
		// one idle cycle sits between back-to-back long exposures
		check_val(32'(b), 32'h0000003c + 32'h1);
	endtask

	task automatic master();
		set_cfg(3'h1, 32'h00000008);
		wait_sig(5, 100, a);
		fire(1'b0, 3, 2, 20, hit, a);
		check_flag(hit, 1'b0);
		fire(1'b0, 6, 2, 20, hit, a);
		check_val(32'(a), 32'(MP + 2));
		wait_sig(4, 50, a);
		check_val(32'(a), 32'h00000008);
		check_flag(frame_start, 1'b1);
		fire(1'b0, 6, 2, 20, hit, b);
		check_flag(hit, 1'b0);
		wait_sig(5, 100, a);
		check_val(32'(a + b), 32'(RD));
		check_flag(strobe, 1'b0);
		// long exposure so a second pulse lands inside it
		set_cfg(3'h1, 32'h0000001e);
		fire(1'b0, 6, 2, 20, hit, a);
		repeat (2) @(posedge clk);
		#1;
		fire(1'b0, 6, 3, 20, hit, a);
		check_flag(hit, 1'b1);
		check_flag(strobe, 1'b1);
		cfg_mode = 3'h3;
		repeat (2) @(posedge clk);
		#1;
		check_val(32'(active_mode), 32'(mode_master));
		wait_sig(4, 100, a);
		wait_sig(5, 100, a);
	endtask

	task automatic master_ovl();
		set_cfg(3'h2, 32'h0000000a);
		fire(1'b0, 6, 2, 20, hit, a);
		wait_sig(4, 50, a);
		check_flag(frame_start, 1'b1);
		fire(1'b0, 6, 2, 12, hit, b);
		check_flag(hit, 1'b0);
		repeat (15) @(posedge clk);
		#1;
		fire(1'b0, 6, 2, 20, hit, b);
		check_flag(hit, 1'b1);
		check_flag(reading, 1'b1);
		wait_sig(4, 50, a);
		check_flag(frame_start, 1'b1);
		wait_sig(5, 100, a);
	endtask

	task automatic slave(input logic [2:0] m);
		set_cfg(m, 32'h00000008);
		fire(1'b1, 20, 2, 30, hit, a);
		check_flag(hit, 1'b1);
		wait_sig(4, 50, a);
		check_val(32'(a), 32'(20 - MP + 1));
		if (m == 3'h4) begin
			repeat (20) @(posedge clk);
			#1;
			fire(1'b1, 20, 2, 30, hit, b);
			check_flag(hit, 1'b1);
			check_flag(reading, 1'b1);
			wait_sig(4, 50, a);
		end
		wait_sig(5, 100, a);
	endtask

////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		modes_and_led();
		free_run();
		master();
		master_ovl();
		pol_high = 1'b0;
		src_ext = 1'b1;
		src.set_pol(1'b0);
		slave(3'h3);
		slave(3'h4);
		finish_test();
	end
endmodule
